/* File: lcf_defines.vh */
// Register map, field layout, reset values and pulse counts of the loss-of-signal config bank
`ifndef LCF_DEFINES_VH
`define LCF_DEFINES_VH

// Printed offsets are register indices; byte address is four times the index
`define LCF_IDX_W 11
`define LCF_CFG_IDX_BASE 11'h00d
`define LCF_CFG_IDX_LAST 11'h3cd
`define LCF_CFG_IDX_STRIDE 11'h040
`define LCF_CFG_IDX_LOW 6'h0d
`define LCF_LINE_STAT_IDX 11'h400
`define LCF_TX_STAT_IDX 11'h401
`define LCF_MODE_IDX 11'h402

// Configuration register fields
`define LCF_CFG_RESET 8'h15
`define LCF_CRIT_BIT 7
`define LCF_LTHR_MSB 6
`define LCF_LTHR_LSB 4
`define LCF_TTHR_MSB 3
`define LCF_TTHR_LSB 2
`define LCF_TPER_MSB 1
`define LCF_TPER_LSB 0

// Mode register fields
`define LCF_MODE_RESET 3'h0
`define LCF_MODE_E1_BIT 0
`define LCF_MODE_MON_BIT 1
`define LCF_MODE_SE_BIT 2

// Transmit loss periods in pulse intervals
`define LCF_TPER_16 12'd16
`define LCF_TPER_32 12'd32
`define LCF_TPER_64 12'd64

// Line loss interval counts per criteria set and line mode
`define LCF_N_STD0_T1 12'd175
`define LCF_N_STD0_E1 12'd32
`define LCF_N_STD1_T1 12'd1544
`define LCF_N_STD1_E1 12'd2048

`endif

/* File: lcf_cfg_reg.v */
// One channel's 8-bit loss-of-signal configuration register
`timescale 1ns/100ps
`default_nettype none
`include "lcf_defines.vh"

module lcf_cfg_reg (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Write port
  input wire wr_en,
  input wire [7:0] wr_data,
  // Stored value
  output reg [7:0] cfg_reg
);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= `LCF_CFG_RESET;
    end else if (wr_en) begin
      cfg_reg <= wr_data;
    end
  end

endmodule
`default_nettype wire

/* File: lcf_loss_det.v */
// Consecutive low-amplitude pulse interval counter with a sticky-until-pulse loss flag
`timescale 1ns/100ps
`default_nettype none

module lcf_loss_det #(
  parameter CNT_W = 12
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Pulse interval strobe and comparator result
  input wire interval_tick,
  input wire amp_above,
  input wire [CNT_W-1:0] limit,
  // Loss indication
  output reg loss_reg
);

  reg [CNT_W-1:0] cnt_reg;
  reg [CNT_W-1:0] cnt_next;
  reg loss_next;

  always @* begin
    cnt_next = cnt_reg;
    loss_next = loss_reg;
    if (interval_tick) begin
      if (amp_above) begin
        // A pulse above threshold ends the run and clears the loss at once
        cnt_next = {CNT_W{1'b0}};
        loss_next = 1'b0;
      end else begin
        // Saturate so a long outage cannot wrap the count back to zero; the flag holds either way
        if (cnt_reg != {CNT_W{1'b1}}) begin
          cnt_next = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        if (cnt_next >= limit) begin
          loss_next = 1'b1;
        end
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= {CNT_W{1'b0}};
      loss_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      loss_reg <= loss_next;
    end
  end

endmodule
`default_nettype wire

/* File: lcf_top.v */
// Loss-of-signal configuration bank: APB slave, per-channel config and loss detectors
//
// Behaviour
// - Each channel has an 8-bit read/write config register resetting to 15 hex.
// - Sixteen copies at index 00D to 3CD in steps of 40 hex.
// - Bit 7 picks the loss criteria set: 0 default set, 1 alternate set.
// - Line loss declared after N consecutive intervals below the line threshold.
// - N follows the criteria bit, not a separate field.
// - Bits 6..4 are the line threshold code, meaning depends on monitor mode.
// - Normal receive: codes 0..7 give 0.5 to 2.0 Vpp, default code 1.
// - Monitor mode: codes 0..3 give 1.0 to 2.2 Vpp, codes 4..7 reserved.
// - Transmit loss declared after the selected period below the transmit threshold.
// - Transmit loss clears as soon as one pulse exceeds the transmit threshold.
// - Bits 1..0 pick the period: 16, 32 or 64 pulses, default 32.
`timescale 1ns/100ps
`default_nettype none
`include "lcf_defines.vh"

module lcf_top #(
  parameter NUM_CH = 16,
  parameter CNT_W = 12,
  parameter [CNT_W-1:0] N_STD0_T1 = `LCF_N_STD0_T1,
  parameter [CNT_W-1:0] N_STD0_E1 = `LCF_N_STD0_E1,
  parameter [CNT_W-1:0] N_STD1_T1 = `LCF_N_STD1_T1,
  parameter [CNT_W-1:0] N_STD1_E1 = `LCF_N_STD1_E1
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [12:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Analog front end: per-channel pulse interval strobes and comparator results
  input wire [NUM_CH-1:0] line_interval_tick,
  input wire [NUM_CH-1:0] line_amp_above,
  input wire [NUM_CH-1:0] tx_interval_tick,
  input wire [NUM_CH-1:0] tx_amp_above,
  // Analog front end: threshold codes and interface mode
  output wire [3*NUM_CH-1:0] line_amp_threshold,
  output wire [2*NUM_CH-1:0] tx_amp_threshold,
  output wire [NUM_CH-1:0] loss_criteria_select,
  output reg e1_mode,
  output reg line_monitor_mode,
  output reg tx_single_ended,
  // Loss indications
  output wire [NUM_CH-1:0] line_signal_loss,
  output wire [NUM_CH-1:0] tx_signal_loss
);

  // Decoded access
  wire [`LCF_IDX_W-1:0] acc_idx;
  wire acc_aligned;
  wire acc_setup;
  wire acc_done;
  wire acc_wr;
  wire cfg_hit;
  wire [3:0] cfg_ch;

  // Register state
  reg [2:0] mode_reg;
  reg [2:0] mode_next;
  reg [31:0] prdata_next;
  reg pslverr_next;
  wire [7:0] cfg_q [0:NUM_CH-1];

  // Index lookup: config copies sit at the low offset of each 40 hex block
  function cfg_idx_hit;
    input [`LCF_IDX_W-1:0] idx;
    begin
      cfg_idx_hit = (idx >= `LCF_CFG_IDX_BASE) && (idx <= `LCF_CFG_IDX_LAST) &&
        (idx[5:0] == `LCF_CFG_IDX_LOW);
    end
  endfunction

  function [3:0] cfg_idx_ch;
    input [`LCF_IDX_W-1:0] idx;
    begin
      cfg_idx_ch = idx[9:6];
    end
  endfunction

  // Line loss interval count from criteria set and line mode
  function [CNT_W-1:0] line_limit;
    input crit;
    input e1;
    begin
      case ({crit, e1})
        2'b00: line_limit = N_STD0_T1;
        2'b01: line_limit = N_STD0_E1;
        2'b10: line_limit = N_STD1_T1;
        2'b11: line_limit = N_STD1_E1;
        default: line_limit = N_STD0_T1;
      endcase
    end
  endfunction

  // Transmit loss period in pulses; code 1x is 64 either way
  function [CNT_W-1:0] tx_limit;
    input [1:0] code;
    begin
      case (code)
        2'b00: tx_limit = `LCF_TPER_16;
        2'b01: tx_limit = `LCF_TPER_32;
        default: tx_limit = `LCF_TPER_64;
      endcase
    end
  endfunction

  assign acc_idx = paddr[12:2];
  assign acc_aligned = (paddr[1:0] == 2'b00);
  assign acc_setup = psel && !penable;
  // Completion edge: the only edge at which a write lands
  assign acc_done = psel && penable && pready;
  assign acc_wr = acc_done && pwrite && !pslverr && pstrb[0];
  assign cfg_hit = cfg_idx_hit(acc_idx);
  assign cfg_ch = cfg_idx_ch(acc_idx);

  // Per-channel register, detectors and front-end code routing
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : gen_ch
      wire [7:0] q;
      wire wr_ch;

      assign wr_ch = acc_wr && cfg_hit && (cfg_ch == g);

      lcf_cfg_reg u_cfg (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_ch),
        .wr_data(pwdata[7:0]),
        .cfg_reg(q)
      );

      assign cfg_q[g] = q;

      // Criteria bit feeds the analog side and the line interval count
      assign loss_criteria_select[g] = q[`LCF_CRIT_BIT];
      // Code passes as stored; the front end reads it per monitor mode
      assign line_amp_threshold[3*g+2:3*g] = q[`LCF_LTHR_MSB:`LCF_LTHR_LSB];
      // Same code drives differential or single-ended comparator scales
      assign tx_amp_threshold[2*g+1:2*g] = q[`LCF_TTHR_MSB:`LCF_TTHR_LSB];

      lcf_loss_det #(
        .CNT_W(CNT_W)
      ) u_line_det (
        .pclk(pclk),
        .presetn(presetn),
        .interval_tick(line_interval_tick[g]),
        .amp_above(line_amp_above[g]),
        .limit(line_limit(q[`LCF_CRIT_BIT], mode_reg[`LCF_MODE_E1_BIT])),
        .loss_reg(line_signal_loss[g])
      );

      lcf_loss_det #(
        .CNT_W(CNT_W)
      ) u_tx_det (
        .pclk(pclk),
        .presetn(presetn),
        .interval_tick(tx_interval_tick[g]),
        .amp_above(tx_amp_above[g]),
        .limit(tx_limit(q[`LCF_TPER_MSB:`LCF_TPER_LSB])),
        .loss_reg(tx_signal_loss[g])
      );
    end
  endgenerate

  // Read data and error are formed in the setup cycle so they leave flops
  always @* begin
    prdata_next = prdata;
    // Error is only meaningful with ready, so it never outlives the access cycle
    pslverr_next = 1'b0;
    mode_next = mode_reg;
    if (acc_setup) begin
      prdata_next = 32'h0000_0000;
      pslverr_next = 1'b0;
      if (!acc_aligned) begin
        pslverr_next = 1'b1;
      end else if (cfg_hit) begin
        prdata_next = {24'h00_0000, cfg_q[cfg_ch]};
      end else if (acc_idx == `LCF_LINE_STAT_IDX) begin
        prdata_next[NUM_CH-1:0] = line_signal_loss;
        pslverr_next = pwrite;
      end else if (acc_idx == `LCF_TX_STAT_IDX) begin
        prdata_next[NUM_CH-1:0] = tx_signal_loss;
        pslverr_next = pwrite;
      end else if (acc_idx == `LCF_MODE_IDX) begin
        prdata_next[2:0] = mode_reg;
      end else begin
        pslverr_next = 1'b1;
      end
    end
    if (acc_wr && (acc_idx == `LCF_MODE_IDX)) begin
      mode_next = pwdata[2:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      mode_reg <= `LCF_MODE_RESET;
      e1_mode <= 1'b0;
      line_monitor_mode <= 1'b0;
      tx_single_ended <= 1'b0;
    end else begin
      prdata <= prdata_next;
      pslverr <= pslverr_next;
      // Ready rises for exactly the one access cycle after setup
      pready <= acc_setup;
      mode_reg <= mode_next;
      e1_mode <= mode_next[`LCF_MODE_E1_BIT];
      line_monitor_mode <= mode_next[`LCF_MODE_MON_BIT];
      tx_single_ended <= mode_next[`LCF_MODE_SE_BIT];
    end
  end

endmodule
`default_nettype wire

/* File: lcf_checker.sv */
// Assertions on the ports of the loss-of-signal config bank
`timescale 1ns/100ps
`default_nettype none
module lcf_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [12:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  // Front end and loss flags
  input wire logic [15:0] line_interval_tick,
  input wire logic [15:0] line_amp_above,
  input wire logic [15:0] tx_interval_tick,
  input wire logic [15:0] tx_amp_above,
  input wire logic [47:0] line_amp_threshold,
  input wire logic [31:0] tx_amp_threshold,
  input wire logic [15:0] loss_criteria_select,
  input wire logic [15:0] line_signal_loss,
  input wire logic [15:0] tx_signal_loss
);
  // Run of low transmit ticks on channel 0, saturating so it never wraps to zero
  logic [7:0] low_cnt;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) low_cnt <= 8'h00;
    else if (tx_interval_tick[0]) low_cnt <= tx_amp_above[0] ? 8'h00 :
      low_cnt + {7'h00, low_cnt != 8'hff};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  err_with_ready_a: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access");
  cfg_fields_a: assert property (psel && penable && pready && pwrite && pstrb[0] &&
    paddr == 13'h0034 |=> {loss_criteria_select[0], line_amp_threshold[2:0],
    tx_amp_threshold[1:0]} == $past(pwdata[7:2])) else $error("fields not written");
  tx_clear_a: assert property (tx_interval_tick[0] && tx_amp_above[0] |=>
    !tx_signal_loss[0]) else $error("tx loss not cleared");
  tx_hold_a: assert property (!tx_interval_tick[0] |=> $stable(tx_signal_loss[0]))
    else $error("tx loss moved without tick");
  tx_min_a: assert property ($rose(tx_signal_loss[0]) |-> low_cnt >= 8'd16)
    else $error("tx loss too early");
  tx_max_a: assert property (tx_interval_tick[0] && !tx_amp_above[0] && low_cnt >= 8'd63
    |=> tx_signal_loss[0]) else $error("tx loss too late");
  line_set_a: assert property ($rose(line_signal_loss[0]) |->
    $past(line_interval_tick[0]) && !$past(line_amp_above[0])) else $error("line loss uncaused");
  line_clear_a: assert property (line_interval_tick[0] && line_amp_above[0] |=>
    !line_signal_loss[0]) else $error("line loss not cleared");
endmodule
bind lcf_top lcf_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .pready, .pslverr, .line_interval_tick, .line_amp_above, .tx_interval_tick,
  .tx_amp_above, .line_amp_threshold, .tx_amp_threshold, .loss_criteria_select,
  .line_signal_loss, .tx_signal_loss);
`default_nettype wire

/* File: lcf_afe_model.sv */
// Front-end comparator model: pulse interval strobes and amplitude results
`timescale 1ns/100ps
`default_nettype none
module lcf_afe_model (
  // Clock
  input wire logic pclk,
  // Bench controls
  input wire logic run,
  input wire logic slow,
  input wire logic line_low,
  input wire logic tx_low,
  // Strobes and comparator results
  output var logic [15:0] line_interval_tick,
  output var logic [15:0] line_amp_above,
  output var logic [15:0] tx_interval_tick,
  output var logic [15:0] tx_amp_above
);
  logic ph = 1'b0;
  logic tk;
  assign tk = run && (!slow || ph);
  // Between ticks the result means nothing, so it toggles rather than holding
  always @(posedge pclk) begin
    ph <= !ph;
    line_interval_tick <= {16{tk}};
    tx_interval_tick <= {16{tk}};
    line_amp_above <= tk ? {16{!line_low}} : ~line_amp_above;
    tx_amp_above <= tk ? {16{!tx_low}} : ~tx_amp_above;
  end
  initial begin
    line_amp_above = 16'h0000;
    tx_amp_above = 16'h0000;
  end
endmodule
`default_nettype wire

/* File: test_loss_of_signal_config.sv */
// Self-checking bench for the loss-of-signal config bank
`timescale 1ns/100ps
`default_nettype none
module test_loss_of_signal_config;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [12:0] paddr = 13'h0000;
  logic [31:0] pwdata = 32'h0, prdata, r, tx_amp_threshold;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, e, e1_mode, line_monitor_mode, tx_single_ended;
  logic run = 1'b0, slow = 1'b0, line_low = 1'b0, tx_low = 1'b0;
  logic [15:0] line_interval_tick, line_amp_above, tx_interval_tick, tx_amp_above;
  logic [15:0] loss_criteria_select, line_signal_loss, tx_signal_loss;
  logic [47:0] line_amp_threshold;
  int fail_count = 0, samples_checked = 0, cycles = 0, n;
  always #2.5 pclk = ~pclk;
  lcf_top #(.N_STD0_T1(12'd5), .N_STD0_E1(12'd3), .N_STD1_T1(12'd7), .N_STD1_E1(12'd9)) DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .line_interval_tick, .line_amp_above, .tx_interval_tick, .tx_amp_above,
    .line_amp_threshold, .tx_amp_threshold, .loss_criteria_select, .e1_mode,
    .line_monitor_mode, .tx_single_ended, .line_signal_loss, .tx_signal_loss);
  lcf_afe_model afe (.pclk, .run, .slow, .line_low, .tx_low, .line_interval_tick,
    .line_amp_above, .tx_interval_tick, .tx_amp_above);
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // Idle edge first, so a release never meets the next setup in one time step
  task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench timeout ends this wait
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counts low ticks on channel 0 until the chosen flag rises
  task automatic measure(input logic tx);
    n = 0;
    while ((tx ? tx_signal_loss[0] : line_signal_loss[0]) !== 1'b1 && n < 100) begin
      @(posedge pclk);
      if ((tx ? tx_interval_tick[0] : line_interval_tick[0]) &&
        !(tx ? tx_amp_above[0] : line_amp_above[0])) n++;
      #1;
    end
  endtask
  task automatic t_reset();
    apb(1'b0, 13'h0f34, 32'h0);
    chk(r, 32'h15, "ch15 reset");
    chk({loss_criteria_select[0], line_amp_threshold[2:0], tx_amp_threshold[1:0]},
      32'h5, "reset fields");
    $display("reset test done");
  endtask
  task automatic t_regs();
    for (int k = 0; k < 16; k++)
      apb(1'b1, 13'h0034 + 13'(k * 256), 32'hd0 | k);
    for (int k = 0; k < 16; k++) begin
      apb(1'b0, 13'h0034 + 13'(k * 256), 32'h0);
      chk(r, 32'hd0 | k, "cfg readback");
      chk({line_amp_threshold[3*k+:3], tx_amp_threshold[2*k+:2]}, 5'h14 | k[3:2],
        "fields");
    end
    chk(loss_criteria_select, 32'hffff, "criteria bits");
    apb(1'b0, 13'h0038, 32'h0);
    chk(e, 1'b1, "unmapped");
    // Second reset mid-run: written copies must fall back to the reset value
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 13'h0434, 32'h0);
    chk(r, 32'h15, "ch4 after reset");
    chk(loss_criteria_select, 32'h0, "criteria after reset");
    $display("register test done");
  endtask
  task automatic t_errs();
    apb(1'b1, 13'h0035, 32'h0);
    chk(e, 1'b1, "misaligned");
    apb(1'b1, 13'h1000, 32'h0);
    chk(e, 1'b1, "status write");
    pstrb <= 4'h0;
    apb(1'b1, 13'h0034, 32'h0);
    pstrb <= 4'hf;
    chk(e, 1'b0, "masked write");
    apb(1'b0, 13'h0034, 32'h0);
    chk(r, 32'h15, "kept value");
    apb(1'b0, 13'h1008, 32'h0);
    chk(r, 32'h0, "mode reset");
    $display("error test done");
  endtask
  task automatic t_tx();
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 13'h0034, 32'h14 | c);
      slow <= c[0];
      tx_low <= 1'b1;
      run <= 1'b1;
      measure(1'b1);
      chk(n, c > 1 ? 64 : 16 << c, "tx period");
      // Other channels keep the 32-pulse reset period
      apb(1'b0, 13'h1004, 32'h0);
      chk(r, c == 0 ? 32'h1 : 32'hffff, "tx status");
      tx_low <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(tx_signal_loss[0], 1'b0, "tx clear");
    end
    $display("tx test done");
  endtask
  task automatic t_line();
    int nexp [4] = '{5, 3, 7, 9};
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 13'h1008, {29'h0, m[0], m[1], m[0]});
      apb(1'b1, 13'h0034, {24'h0, m[1], 7'h45});
      line_low <= 1'b1;
      measure(1'b0);
      chk(n, nexp[m], "line count");
      chk({tx_single_ended, line_monitor_mode, e1_mode}, {m[0], m[1], m[0]}, "mode");
      chk(line_amp_threshold[2:0], 3'h4, "reserved code");
      apb(1'b0, 13'h1000, 32'h0);
      chk(r, 32'hffff, "line status");
      apb(1'b0, 13'h1008, 32'h0);
      chk(r, {29'h0, m[0], m[1], m[0]}, "mode readback");
      line_low <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(line_signal_loss[0], 1'b0, "line clear");
    end
    $display("line test done");
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_errs();
    t_tx();
    t_line();
    stop_test();
  end
endmodule
`default_nettype wire
